// file: src/strap_pkg.sv
// Package with strap bit positions, default pull levels and encodings
package strap_pkg;
  // ****************************************
  // Strap bit positions
  // ****************************************
  localparam int STRAP_W = 5;
  localparam int LDO_BIT = 0;
  localparam int BOOT_BIT = 1;
  localparam int DLQ_BIT = 2;
  localparam int LOG_BIT = 3;
  localparam int EDGE_BIT = 4;
  // Weak pull level applied during reset, one bit per strap
  localparam logic [4:0] PULL_DEFAULT = 5'h1A;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic LDO_3V3 = 1'b0;
  localparam logic LDO_1V8 = 1'b1;
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;
  typedef enum logic [1:0] {
    BOOT_SPI = 2'b00,
    BOOT_DOWNLOAD = 2'b01,
    BOOT_UNDEFINED = 2'b10
  } boot_mode_t;
endpackage

// file: src/strap_capture.sv
// Strap capture latch: reloads from the pins each clock in reset, frozen after release
`timescale 1ns/1ps
module strap_capture
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Pins
  input wire logic [STRAP_W-1:0] pin_in,
  // Captured value
  output logic [STRAP_W-1:0] bits
);
  typedef struct packed {
    logic [STRAP_W-1:0] bits;
  } cap_state_t;

  cap_state_t state_r;
  cap_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    // Capture only while reset is held; the last reset cycle wins
    if (srst) begin
      state_nxt.bits = pin_in;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign bits = state_r.bits;

  a_bits_frozen: assert property (@(posedge clock)
    !srst && !$past(srst) |-> bits == $past(bits))
    else $error("Strap bits changed outside reset");
endmodule

// file: src/boot_strap_latch.sv
// Strap latch top: pulls, capture, decoded boot settings, overrides
// Operation
// - Latch five strap pins during any reset
// - Latched strap bits readable by software
// - Weak default pulls on straps during reset
// - Pins revert to normal after reset release
// - Regulator voltage from ldo strap bit
// - Boot source from boot and qualifier straps
// - Boot log on uart0 transmit when enabled
// - SDIO input/output edges from two straps
// - Firmware may override voltage and timing
`timescale 1ns/1ps
module boot_strap_latch
  import strap_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Strap pins: level in, pull level, pull enable
  input wire logic [4:0] strap_pin_in,
  output logic [4:0] strap_pull_level,
  output logic [4:0] strap_pull_en,
  // Normal pin function ownership
  output logic pins_normal,
  // Software readback
  output logic [4:0] strap_value,
  // Firmware overrides
  input wire logic ldo_override_en,
  input wire logic ldo_override_val,
  input wire logic sdio_override_en,
  input wire logic sdio_in_edge_override,
  input wire logic sdio_out_edge_override,
  // Boot log request from boot code
  input wire logic boot_log_data,
  input wire logic boot_done,
  // Decoded settings
  output logic ldo_1v8_sel,
  output boot_mode_t boot_mode,
  output logic uart0_transmit_pin,
  output logic sdio_in_rising,
  output logic sdio_out_rising
);
  // ****************************************
  // Capture
  // ****************************************
  logic [4:0] latched;

  strap_capture u_cap (
    .clock(clock),
    .srst(srst),
    .pin_in(strap_pin_in),
    .bits(latched)
  );

  function automatic boot_mode_t decode_boot(input logic [4:0] s);
    if (s[BOOT_BIT]) begin
      return BOOT_SPI;
    end else if (!s[DLQ_BIT]) begin
      return BOOT_DOWNLOAD;
    end else begin
      return BOOT_UNDEFINED;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [4:0] pull_level;
    logic [4:0] pull_en;
    logic normal;
    logic [4:0] value;
    logic ldo;
    boot_mode_t mode;
    logic txd;
    logic in_rise;
    logic out_rise;
  } top_state_t;

  top_state_t state_r;
  top_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.pull_level = PULL_DEFAULT;
    // Pulls only during reset so the pins are free afterwards
    state_nxt.pull_en = srst ? 5'h1F : 5'h00;
    state_nxt.normal = !srst;
    state_nxt.value = latched;
    // The board must keep this strap low; the flash needs 3.3V
    state_nxt.ldo = ldo_override_en ? ldo_override_val : latched[LDO_BIT];
    state_nxt.mode = decode_boot(latched);
    // Line idles high when silent
    if (srst) begin
      state_nxt.txd = 1'b1;
    end else if (!boot_done && latched[LOG_BIT]) begin
      state_nxt.txd = boot_log_data;
    end else begin
      state_nxt.txd = 1'b1;
    end
    state_nxt.in_rise = sdio_override_en ? sdio_in_edge_override : latched[LOG_BIT];
    state_nxt.out_rise = sdio_override_en ? sdio_out_edge_override : latched[EDGE_BIT];
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign strap_pull_level = state_r.pull_level;
  assign strap_pull_en = state_r.pull_en;
  assign pins_normal = state_r.normal;
  assign strap_value = state_r.value;
  assign ldo_1v8_sel = state_r.ldo;
  assign boot_mode = state_r.mode;
  assign uart0_transmit_pin = state_r.txd;
  assign sdio_in_rising = state_r.in_rise;
  assign sdio_out_rising = state_r.out_rise;

  // ****************************************
  // Checks
  // ****************************************
  a_value_stable: assert property (@(posedge clock)
    !srst [*3] |-> $stable(strap_value))
    else $error("Strap value moved after reset");
  a_value_readback: assert property (@(posedge clock)
    !srst |=> strap_value == $past(latched))
    else $error("Readback differs from latch");
  a_pull_reset: assert property (@(posedge clock)
    srst |=> strap_pull_en == 5'h1F && strap_pull_level == PULL_DEFAULT)
    else $error("Pulls not applied in reset");
  a_pins_release: assert property (@(posedge clock)
    !srst |=> pins_normal && strap_pull_en == 5'h00)
    else $error("Pins not released after reset");
  a_ldo_select: assert property (@(posedge clock)
    !ldo_override_en |=> ldo_1v8_sel == $past(latched[LDO_BIT]))
    else $error("Regulator select mismatch");
  a_boot_spi: assert property (@(posedge clock)
    latched[BOOT_BIT] |=> boot_mode == BOOT_SPI)
    else $error("Boot source not flash");
  a_boot_dl: assert property (@(posedge clock)
    !latched[BOOT_BIT] && !latched[DLQ_BIT] |=> boot_mode == BOOT_DOWNLOAD)
    else $error("Boot source not download");
  a_log_silent: assert property (@(posedge clock)
    !latched[LOG_BIT] |=> uart0_transmit_pin)
    else $error("Transmit pin not silent");
  a_sdio_edges: assert property (@(posedge clock)
    !sdio_override_en |=> {sdio_in_rising, sdio_out_rising}
      == {$past(latched[LOG_BIT]), $past(latched[EDGE_BIT])})
    else $error("SDIO edges mismatch");
  a_sdio_override: assert property (@(posedge clock)
    sdio_override_en |=> sdio_in_rising == $past(sdio_in_edge_override))
    else $error("SDIO override ignored");

  // ****************************************
  // Checks on latch, pulls and decoded settings
  // ****************************************
  // Latch follows the pins only in reset cycles
  a_latch_follow: assert property (@(posedge clock)
    srst
    |=> latched == $past(strap_pin_in))
    else $error("Latch missed pin level in reset");

  a_latch_hold: assert property (@(posedge clock)
    !srst
    |=> latched == $past(latched))
    else $error("Latch moved outside reset");

  // Two reset cycles are enough for the readback to show the pins
  a_value_reset: assert property (@(posedge clock)
    srst ##1 srst
    |=> strap_value == $past(strap_pin_in, 2))
    else $error("Readback not from sampled pins");

  a_pull_level: assert property (@(posedge clock)
    !srst
    |=> strap_pull_level == PULL_DEFAULT)
    else $error("Pull level not default");

  a_pull_enter: assert property (@(posedge clock)
    $rose(srst)
    |=> strap_pull_en == 5'h1F)
    else $error("Pulls late on reset entry");

  a_pins_reset: assert property (@(posedge clock)
    srst
    |=> !pins_normal)
    else $error("Pins normal during reset");

  a_ldo_3v3: assert property (@(posedge clock)
    !ldo_override_en && !latched[LDO_BIT]
    |=> ldo_1v8_sel == LDO_3V3)
    else $error("Regulator not at 3.3V");

  // Undefined mode kept apart so it never boots by accident
  a_boot_undef: assert property (@(posedge clock)
    !latched[BOOT_BIT] && latched[DLQ_BIT]
    |=> boot_mode == BOOT_UNDEFINED)
    else $error("Boot source not undefined");

  a_log_active: assert property (@(posedge clock)
    !srst && !boot_done && latched[LOG_BIT]
    |=> uart0_transmit_pin == $past(boot_log_data))
    else $error("Boot log not on transmit pin");

  a_log_done: assert property (@(posedge clock)
    boot_done
    |=> uart0_transmit_pin)
    else $error("Transmit pin busy after boot");

  a_txd_reset: assert property (@(posedge clock)
    srst
    |=> uart0_transmit_pin)
    else $error("Transmit pin busy in reset");

  a_sdio_in_fall: assert property (@(posedge clock)
    !sdio_override_en && !latched[LOG_BIT]
    |=> sdio_in_rising == EDGE_FALL)
    else $error("SDIO input edge not falling");

  a_sdio_out_rise: assert property (@(posedge clock)
    !sdio_override_en && latched[EDGE_BIT]
    |=> sdio_out_rising == EDGE_RISE)
    else $error("SDIO output edge not rising");

  a_ldo_override: assert property (@(posedge clock)
    ldo_override_en
    |=> ldo_1v8_sel == $past(ldo_override_val))
    else $error("Regulator override ignored");

  a_sdio_out_ovr: assert property (@(posedge clock)
    sdio_override_en
    |=> sdio_out_rising == $past(sdio_out_edge_override))
    else $error("SDIO output override ignored");
endmodule

// file: bench/strap_board.sv
// Board pulls and host outputs that set the strap pin levels
`timescale 1ns/1ps
module strap_board (
  // Host drive
  input wire logic [4:0] drive_en,
  input wire logic [4:0] drive_val,
  // Device pulls
  input wire logic [4:0] pull_level,
  input wire logic [4:0] pull_en,
  // Pin levels
  output logic [4:0] pin
);
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      // Host level wins over weak pull; host never drives the ldo strap high
      if (drive_en[i]) begin
        pin[i] = (i == 0) ? 1'b0 : drive_val[i];
      end else if (pull_en[i]) begin
        pin[i] = pull_level[i];
      end else begin
        // Floating pin shows a level that cannot be mistaken for a hold
        pin[i] = ~drive_val[i];
      end
    end
  end
endmodule

// file: bench/tb.sv
// Self-checking bench for the strap latch
`timescale 1ns/1ps
module tb;
  import strap_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [4:0] den = 5'h00, dval = 5'h00, pin, pl, pe, sv, e;
  logic ld_en = 0, ld_v = 0, sd_en = 0, sd_i = 0, sd_o = 0, log_d = 0, done = 0;
  logic pn, l18, txd, s_in, s_out;
  boot_mode_t bm;
  int error_cnt = 0, n_checks = 0, seed = 13;
  initial forever #2 clock = ~clock;
  strap_board u_board (.drive_en(den), .drive_val(dval), .pull_level(pl), .pull_en(pe),
    .pin(pin));
  boot_strap_latch u_dut (.clock(clock), .srst(srst), .strap_pin_in(pin),
    .strap_pull_level(pl), .strap_pull_en(pe), .pins_normal(pn), .strap_value(sv),
    .ldo_override_en(ld_en), .ldo_override_val(ld_v), .sdio_override_en(sd_en),
    .sdio_in_edge_override(sd_i), .sdio_out_edge_override(sd_o), .boot_log_data(log_d),
    .boot_done(done), .ldo_1v8_sel(l18), .boot_mode(bm), .uart0_transmit_pin(txd),
    .sdio_in_rising(s_in), .sdio_out_rising(s_out));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(string n, logic [4:0] x, logic [4:0] s);
    n_checks++;
    if (x !== s) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  function automatic logic [4:0] mode(logic [4:0] s);
    return s[BOOT_BIT] ? 5'(BOOT_SPI) : (s[DLQ_BIT] ? 5'(BOOT_UNDEFINED) : 5'(BOOT_DOWNLOAD));
  endfunction
  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  // ****************************************
  // Trials: corners first, then random straps
  // ****************************************
  initial begin
    repeat (4) @(posedge clock);
    for (int t = 0; t < 40; t++) begin
      @(posedge clock);
      srst <= 1'b1;
      den <= (t == 0) ? 5'h00 : ((t < 3) ? 5'h1F : 5'($random(seed)));
      dval <= (t == 1) ? 5'h00 : ((t == 2) ? 5'h04 : 5'($random(seed)));
      {ld_en, ld_v, sd_en, sd_i, sd_o, log_d} <= 6'($random(seed));
      done <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk("pull_en", 5'h1F, pe);
      chk("pull_level", PULL_DEFAULT, pl);
      chk("pins_normal", 5'h00, pn);
      chk("txd_reset", 5'h01, txd);
      e = (den & dval & 5'h1E) | (~den & PULL_DEFAULT);
      @(posedge clock);
      // Pins move right after release; the latch must not follow them
      srst <= 1'b0;
      den <= 5'h1F;
      dval <= ~e;
      repeat (3) @(posedge clock);
      #1;
      chk("strap_value", e, sv);
      chk("pins_normal", 5'h01, pn);
      chk("pull_en", 5'h00, pe);
      chk("ldo_1v8", ld_en ? ld_v : e[LDO_BIT], l18);
      chk("boot_mode", mode(e), 5'(bm));
      chk("sdio_in", sd_en ? sd_i : e[LOG_BIT], s_in);
      chk("sdio_out", sd_en ? sd_o : e[EDGE_BIT], s_out);
      chk("txd_log", e[LOG_BIT] ? log_d : 1'b1, txd);
      @(posedge clock);
      done <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      chk("txd_done", 5'h01, txd);
    end
    conclude();
  end
endmodule
